// [ocdpc_channel.sv]
// Output channel configuration registers, divider and driver selection
`timescale 1ns/100ps
`default_nettype none

// How it works
// R01: Divider ratio is the ten-bit divide value plus one; zero passes through.
// R02: Divide value joins eight low bits with two bits of the next address.
// R03: Start is delayed by the eleven-bit phase offset in input half periods.
// R04: Phase offset joins eight low bits with three bits of the next address.
// R05: Sync restarts the divider unless the sync exclude bit is set.
// R06: Differential polarity field picks high, noninverting, inverting or low.
// R07: Driver type field picks current level, high swing, boost or single ended.
// R08: Positive leg single ended driver is enabled by its bit, off by default.
// R09: Positive leg polarity field picks high, noninverting, inverting or low.
// R10: Negative leg single ended driver is enabled by its bit, off by default.
// R11: Negative leg polarity field picks high, noninverting, inverting or low.
// R12: Divider power down stops the divider with a static low level.
// R13: Single ended enables act only in single ended driver type.
module ocdpc_channel (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sync_req,
   output logic out_p,
   output logic out_p_oe,
   output logic out_n,
   output logic out_n_oe,
   output logic [2:0] driver_type,
   output logic half_step,
   output logic div_bypass
);

   typedef struct packed {
      logic [7:0] drv;
      logic [7:0] se;
      logic [7:0] div_low;
      logic [1:0] div_high;
      logic [7:0] ph_low;
      logic [2:0] ph_high;
      logic [7:0] rdata;
      logic p;
      logic p_oe;
      logic n;
      logic n_oe;
   } ocdpc_regs_t;

   ocdpc_regs_t s_q;
   ocdpc_regs_t s_d;
   logic [9:0] div_value;
   logic [10:0] phase_offset;
   logic [1:0] diff_pol;
   logic [1:0] pos_pol;
   logic [1:0] neg_pol;
   logic se_mode;
   logic div_level;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // One polarity decode shared by the differential and both single legs
   function automatic logic apply_pol(input logic [1:0] pol, input logic lvl);
      logic r;
      r = 1'b0;
      case (pol)
         ocdpc_pkg::POL_FORCE_HIGH: r = 1'b1;
         ocdpc_pkg::POL_NONINV: r = lvl;
         ocdpc_pkg::POL_INVERT: r = !lvl;
         ocdpc_pkg::POL_FORCE_LOW: r = 1'b0;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // Field views of the stored registers
   assign div_value = {s_q.div_high, s_q.div_low}; // see R02
   assign phase_offset = {s_q.ph_high, s_q.ph_low}; // see R04
   assign diff_pol = s_q.drv[ocdpc_pkg::DRV_POL_LSB +: 2];
   assign pos_pol = s_q.se[ocdpc_pkg::SE_POS_POL_LSB +: 2];
   assign neg_pol = s_q.se[ocdpc_pkg::SE_NEG_POL_LSB +: 2];
   assign driver_type = s_q.drv[ocdpc_pkg::DRV_TYPE_LSB +: 3]; // see R07
   // Both top codes release the differential stage to the single legs
   assign se_mode = (driver_type[2:1] == ocdpc_pkg::TYPE_SE_TOP); // see R07
   assign div_bypass = (div_value == 10'h000); // see R01

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   ocdpc_divider u_div (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .div_value(div_value),
      .phase_offset(phase_offset),
      .power_down(s_q.drv[ocdpc_pkg::DRV_PD_BIT]),
      .sync_exclude(s_q.drv[ocdpc_pkg::DRV_SYNCX_BIT]),
      .sync_req(sync_req),
      .div_level(div_level),
      .div_tick(),
      .half_step(half_step)
   );

   // ----------------------------------------------------------------
   // Register writes, read mux and pin drive
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Reserved bits are never stored, so they always read back zero
      if (reg_wr) begin
         case (reg_addr)
            ocdpc_pkg::ADDR_DRIVER: s_d.drv = reg_wdata & ocdpc_pkg::MASK_DRIVER;
            ocdpc_pkg::ADDR_SINGLE: s_d.se = reg_wdata & ocdpc_pkg::MASK_SINGLE;
            ocdpc_pkg::ADDR_DIV_LOW: s_d.div_low = reg_wdata; // see R02
            ocdpc_pkg::ADDR_DIV_HIGH: s_d.div_high = reg_wdata[1:0]; // see R02
            ocdpc_pkg::ADDR_PHASE_LOW: s_d.ph_low = reg_wdata; // see R04
            ocdpc_pkg::ADDR_PHASE_HIGH: s_d.ph_high = reg_wdata[2:0]; // see R04
            default: s_d.drv = s_q.drv;
         endcase
      end
      // Read data is registered; unmapped offsets answer zero
      case (reg_addr)
         ocdpc_pkg::ADDR_DRIVER: s_d.rdata = s_q.drv;
         ocdpc_pkg::ADDR_SINGLE: s_d.rdata = s_q.se;
         ocdpc_pkg::ADDR_DIV_LOW: s_d.rdata = s_q.div_low;
         ocdpc_pkg::ADDR_DIV_HIGH: s_d.rdata = {6'h00, s_q.div_high};
         ocdpc_pkg::ADDR_PHASE_LOW: s_d.rdata = s_q.ph_low;
         ocdpc_pkg::ADDR_PHASE_HIGH: s_d.rdata = {5'h00, s_q.ph_high};
         default: s_d.rdata = ocdpc_pkg::RST_ZERO;
      endcase
      if (se_mode) begin // see R13
         s_d.p_oe = s_q.se[ocdpc_pkg::SE_POS_EN_BIT]; // see R08
         s_d.p = s_d.p_oe && apply_pol(pos_pol, div_level); // see R09
         s_d.n_oe = s_q.se[ocdpc_pkg::SE_NEG_EN_BIT]; // see R10
         s_d.n = s_d.n_oe && apply_pol(neg_pol, div_level); // see R11
      end else begin
         // Differential driver owns both pins as a complementary pair
         s_d.p_oe = 1'b1; // see R13
         s_d.n_oe = 1'b1;
         s_d.p = apply_pol(diff_pol, div_level); // see R06
         s_d.n = !s_d.p;
      end
   end

   // Register file
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{drv: ocdpc_pkg::RST_DRIVER, se: ocdpc_pkg::RST_SINGLE,
                  div_low: ocdpc_pkg::RST_ZERO, div_high: ocdpc_pkg::RST_DIV_HIGH,
                  ph_low: ocdpc_pkg::RST_ZERO, ph_high: ocdpc_pkg::RST_PHASE_HIGH,
                  rdata: ocdpc_pkg::RST_ZERO, p: 1'b0, p_oe: 1'b0, n: 1'b0, n_oe: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign out_p = s_q.p;
   assign out_p_oe = s_q.p_oe;
   assign out_n = s_q.n;
   assign out_n_oe = s_q.n_oe;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   property p_div_join;
      reg_wr && reg_addr == ocdpc_pkg::ADDR_DIV_HIGH
         |=> div_value[9:8] == $past(reg_wdata[1:0]) && div_value[7:0] == $past(s_q.div_low);
   endproperty
   a_div_join: assert property (p_div_join) else $error("divide high bits not joined"); // see R02

   property p_ph_join;
      reg_wr && reg_addr == ocdpc_pkg::ADDR_PHASE_HIGH
         |=> phase_offset[10:8] == $past(reg_wdata[2:0]) && phase_offset[7:0] == $past(s_q.ph_low);
   endproperty
   a_ph_join: assert property (p_ph_join) else $error("phase high bits not joined"); // see R04

   // Release edge excluded: pins still hold reset values one edge after it
   property p_diff_noninv;
      reset_n && !se_mode && diff_pol == ocdpc_pkg::POL_NONINV
         |=> out_p == $past(div_level) && out_n == !$past(div_level) && out_p_oe && out_n_oe;
   endproperty
   a_diff_noninv: assert property (p_diff_noninv) else $error("differential polarity wrong"); // see R06

   property p_diff_forced;
      !se_mode && diff_pol == ocdpc_pkg::POL_FORCE_HIGH |=> out_p && !out_n;
   endproperty
   a_diff_forced: assert property (p_diff_forced) else $error("forced high not held"); // see R06

   property p_pos_off;
      se_mode && !s_q.se[ocdpc_pkg::SE_POS_EN_BIT] |=> !out_p_oe && !out_p;
   endproperty
   a_pos_off: assert property (p_pos_off) else $error("disabled positive leg drives"); // see R08

   property p_pos_low;
      se_mode && s_q.se[ocdpc_pkg::SE_POS_EN_BIT] && pos_pol == ocdpc_pkg::POL_FORCE_LOW
         |=> out_p_oe && !out_p;
   endproperty
   a_pos_low: assert property (p_pos_low) else $error("positive leg not forced low"); // see R09

   property p_neg_inv;
      se_mode && s_q.se[ocdpc_pkg::SE_NEG_EN_BIT] && neg_pol == ocdpc_pkg::POL_INVERT
         |=> out_n_oe && out_n == !$past(div_level);
   endproperty
   a_neg_inv: assert property (p_neg_inv) else $error("negative leg not inverting"); // see R11

   property p_neg_off;
      se_mode && !s_q.se[ocdpc_pkg::SE_NEG_EN_BIT] |=> !out_n_oe;
   endproperty
   a_neg_off: assert property (p_neg_off) else $error("disabled negative leg drives"); // see R10

   property p_diff_owns;
      reset_n && !se_mode |=> out_p_oe && out_n_oe && out_p != out_n;
   endproperty
   a_diff_owns: assert property (p_diff_owns) else $error("differential pins not paired"); // see R13

   c_se_mode: cover property (se_mode && s_q.se[ocdpc_pkg::SE_POS_EN_BIT] ##1 out_p_oe);
   c_pd: cover property (reg_wr && reg_addr == ocdpc_pkg::ADDR_DRIVER
      && reg_wdata[ocdpc_pkg::DRV_PD_BIT]);

endmodule

`default_nettype wire

// [ocdpc_pkg.sv]
// Shared constants and types of the output channel divider and phase block
package ocdpc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DRIVER = 8'h1f;
   localparam logic [7:0] ADDR_SINGLE = 8'h20;
   localparam logic [7:0] ADDR_DIV_LOW = 8'h21;
   localparam logic [7:0] ADDR_DIV_HIGH = 8'h22;
   localparam logic [7:0] ADDR_PHASE_LOW = 8'h23;
   localparam logic [7:0] ADDR_PHASE_HIGH = 8'h24;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DRV_PD_BIT = 7;
   localparam int DRV_SYNCX_BIT = 6;
   localparam int DRV_POL_LSB = 4;
   localparam int DRV_TYPE_LSB = 1;
   localparam int SE_POS_EN_BIT = 7;
   localparam int SE_POS_POL_LSB = 5;
   localparam int SE_NEG_EN_BIT = 4;
   localparam int SE_NEG_POL_LSB = 2;

   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_DRIVER = 8'h14;
   // Both single ended legs come up disabled and forced high
   localparam logic [7:0] RST_SINGLE = 8'h00;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] MASK_DRIVER = 8'hfe;
   localparam logic [7:0] MASK_SINGLE = 8'hfc;
   localparam logic [1:0] RST_DIV_HIGH = 2'h0;
   localparam logic [2:0] RST_PHASE_HIGH = 3'h0;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] POL_FORCE_HIGH = 2'h0;
   localparam logic [1:0] POL_NONINV = 2'h1;
   localparam logic [1:0] POL_INVERT = 2'h2;
   localparam logic [1:0] POL_FORCE_LOW = 2'h3;
   localparam logic [1:0] TYPE_SE_TOP = 2'h3;

   typedef enum logic [2:0] {
      OCDPC_OFF = 3'h1,
      OCDPC_WAIT = 3'h2,
      OCDPC_RUN = 3'h4
   } ocdpc_state_t;

endpackage

// [ocdpc_divider.sv]
// Channel divider with phase offset start delay and sync restart
`timescale 1ns/100ps
`default_nettype none

module ocdpc_divider (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [9:0] div_value,
   input wire logic [10:0] phase_offset,
   input wire logic power_down,
   input wire logic sync_exclude,
   input wire logic sync_req,
   output logic div_level,
   output logic div_tick,
   output logic half_step
);

   typedef struct packed {
      ocdpc_pkg::ocdpc_state_t state;
      logic [9:0] cnt;
      logic level;
      logic tick;
      logic half;
   } ocdpc_div_t;

   ocdpc_div_t s_q;
   ocdpc_div_t s_d;
   logic [10:0] high_len;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // High phase is ceil(N/2) counts so odd ratios stay near 50 percent
   assign high_len = 11'({1'b0, div_value} + 11'h2) >> 1;

   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      s_d.half = phase_offset[0]; // Odd half period left to the analog delay line
      if (power_down) begin // see R12
         s_d.state = ocdpc_pkg::OCDPC_OFF;
         s_d.cnt = 10'h000;
         s_d.level = 1'b0;
      end else if (sync_req && !sync_exclude) begin // see R05
         s_d.state = ocdpc_pkg::OCDPC_WAIT;
         s_d.cnt = 10'h000;
         s_d.level = 1'b0;
      end else begin
         case (s_q.state)
            ocdpc_pkg::OCDPC_OFF: begin
               s_d.state = ocdpc_pkg::OCDPC_WAIT;
               s_d.cnt = 10'h000;
            end
            ocdpc_pkg::OCDPC_WAIT: begin
               // Whole input periods of the offset, half steps counted in pairs
               if (s_q.cnt >= phase_offset[10:1]) begin // see R03
                  s_d.state = ocdpc_pkg::OCDPC_RUN;
                  s_d.cnt = 10'h000;
                  s_d.level = 1'b1;
                  s_d.tick = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 10'h001;
               end
            end
            ocdpc_pkg::OCDPC_RUN: begin
               // Not equality: a ratio lowered below the count must not run to wrap
               if (s_q.cnt >= div_value) begin // see R01
                  s_d.cnt = 10'h000;
                  s_d.level = 1'b1;
                  s_d.tick = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 10'h001;
                  s_d.level = ({1'b0, s_d.cnt} < high_len);
               end
            end
            default: begin
               s_d.state = ocdpc_pkg::OCDPC_OFF;
               s_d.cnt = 10'h000;
               s_d.level = 1'b0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '{state: ocdpc_pkg::OCDPC_OFF, cnt: 10'h000, level: 1'b0, tick: 1'b0,
                  half: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign div_level = s_q.level;
   assign div_tick = s_q.tick;
   assign half_step = s_q.half;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   property p_pd_hold;
      power_down |=> (s_q.state == ocdpc_pkg::OCDPC_OFF) && !div_level && !div_tick;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("divider runs while powered down"); // see R12

   property p_sync_restart;
      sync_req && !sync_exclude && !power_down |=> s_q.state == ocdpc_pkg::OCDPC_WAIT && !div_level;
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("sync did not restart"); // see R05

   property p_sync_masked;
      sync_req && sync_exclude && !power_down && s_q.state == ocdpc_pkg::OCDPC_RUN
         |=> s_q.state == ocdpc_pkg::OCDPC_RUN;
   endproperty
   a_sync_masked: assert property (p_sync_masked) else $error("excluded divider was synced"); // see R05

   property p_ratio_edge;
      s_q.state == ocdpc_pkg::OCDPC_RUN && s_q.cnt == div_value && !power_down
         && !(sync_req && !sync_exclude) |=> div_tick && s_q.cnt == 10'h000;
   endproperty
   a_ratio_edge: assert property (p_ratio_edge) else $error("divider missed its period end"); // see R01

   property p_bypass;
      (s_q.state == ocdpc_pkg::OCDPC_RUN && div_value == 10'h000 && !power_down && !sync_req)[*2]
         |-> div_tick && div_level;
   endproperty
   a_bypass: assert property (p_bypass) else $error("ratio one is not a pass through"); // see R01

   property p_phase_start;
      s_q.state == ocdpc_pkg::OCDPC_WAIT && s_q.cnt >= phase_offset[10:1] && !power_down
         && !sync_req |=> s_q.state == ocdpc_pkg::OCDPC_RUN && div_tick;
   endproperty
   a_phase_start: assert property (p_phase_start) else $error("phase wait overran"); // see R03

   c_sync: cover property (sync_req && !sync_exclude ##1 s_q.state == ocdpc_pkg::OCDPC_WAIT);
   c_run: cover property (s_q.state == ocdpc_pkg::OCDPC_RUN && div_value == 10'h003 && div_tick);

endmodule

`default_nettype wire

// [ocdpc_clock_sink.sv]
// Downstream clock receiver model that measures period and high time
`timescale 1ns/100ps
`default_nettype none

module ocdpc_clock_sink (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic pin,
   input wire logic pin_oe,
   output logic [15:0] period,
   output logic [15:0] high_time
);
   typedef struct packed {
      logic prev;
      logic [15:0] cyc;
      logic [15:0] hi;
      logic [15:0] period;
      logic [15:0] high;
   } ocdpc_sink_state_t;
   ocdpc_sink_state_t st_q;
   ocdpc_sink_state_t st_d;
   logic rx;

   // Undriven pin reads low through the load termination
   assign rx = pin_oe & pin;

   // Edge to edge counting; wraps only after 65535 cycles, far above 1024
   always_comb begin
      st_d = st_q;
      st_d.prev = rx;
      st_d.cyc = st_q.cyc + 16'h0001;
      if (rx) begin
         st_d.hi = st_q.hi + 16'h0001;
      end
      if (rx && !st_q.prev) begin
         st_d.period = st_q.cyc;
         st_d.cyc = 16'h0001;
         st_d.hi = 16'h0001;
      end
      if (!rx && st_q.prev) begin
         st_d.high = st_q.hi;
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign period = st_q.period;
   assign high_time = st_q.high;
endmodule
`default_nettype wire

// [ocdpc_channel_bench.sv]
// Self-checking bench of the output channel configuration block
`timescale 1ns/100ps
`default_nettype none

`define check_eq(name, exp, got) begin check_count++; if ((got) !== (exp)) begin \
   error_cnt++; $display("Error %s expected %h seen %h", name, exp, got); end end

module ocdpc_channel_bench;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic sync_req = 1'b0;
   logic [7:0] reg_rdata;
   logic out_p, out_p_oe, out_n, out_n_oe;
   logic [2:0] driver_type;
   logic half_step, div_bypass;
   logic [15:0] period, high_time;
   logic [7:0] rd;
   logic [3:0] exp4;
   int error_cnt = 0;
   int check_count = 0;
   int lat;
   logic [7:0] addrs [7] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
   logic [7:0] rst_v [7] = '{8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wr_v [7] = '{8'hfe, 8'hfc, 8'hff, 8'h03, 8'hff, 8'h07, 8'h00};
   logic [10:0] ph_v [3] = '{11'h002, 11'h101, 11'h7ff};
   logic [9:0] dv_v [3] = '{10'h001, 10'h004, 10'h3ff};

   // 20 MHz clock
   always #25 clk_sys = ~clk_sys;

   ocdpc_channel ocdpc_channel_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sync_req(sync_req), .out_p(out_p),
      .out_p_oe(out_p_oe), .out_n(out_n), .out_n_oe(out_n_oe), .driver_type(driver_type),
      .half_step(half_step), .div_bypass(div_bypass)
   );

   ocdpc_clock_sink ocdpc_clock_sink_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .pin(out_p), .pin_oe(out_p_oe),
      .period(period), .high_time(high_time)
   );

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("Checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data is registered, so it is sampled one edge after the address
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      @(posedge clk_sys);
      @(negedge clk_sys);
      d = reg_rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic set_div(input logic [9:0] d);
      reg_write(ocdpc_pkg::ADDR_DIV_LOW, d[7:0]);
      reg_write(ocdpc_pkg::ADDR_DIV_HIGH, {6'h00, d[9:8]});
   endtask

   task automatic set_phase(input logic [10:0] p);
      reg_write(ocdpc_pkg::ADDR_PHASE_LOW, p[7:0]);
      reg_write(ocdpc_pkg::ADDR_PHASE_HIGH, {5'h00, p[10:8]});
   endtask

   // Pulse sync, then count cycles until the pin rises; bounded against a hang
   task automatic sync_lat(output int n);
      @(posedge clk_sys);
      sync_req <= 1'b1;
      @(posedge clk_sys);
      sync_req <= 1'b0;
      @(posedge clk_sys);
      n = 0;
      @(negedge clk_sys);
      while (out_p !== 1'b1) begin
         n++;
         if (n > 3000) begin
            error_cnt++;
            finish_test();
         end
         @(negedge clk_sys);
      end
   endtask

   function automatic logic pol_of(input logic [1:0] p, input logic lvl);
      case (p)
         2'h0: pol_of = 1'b1;
         2'h1: pol_of = lvl;
         2'h2: pol_of = ~lvl;
         default: pol_of = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      // Reset values, then all-ones writes with reserved bits dropped
      for (int i = 0; i < 7; i++) begin
         reg_read(addrs[i], rd);
         `check_eq("reset value", rst_v[i], rd)
      end
      for (int i = 0; i < 7; i++) begin
         reg_write(addrs[i], 8'hff);
         reg_read(addrs[i], rd);
         `check_eq("write back", wr_v[i], rd)
      end
      `check_eq("driver type", 3'h7, driver_type)
      for (int i = 0; i < 6; i++) begin
         reg_write(addrs[i], rst_v[i]);
      end
      settle(3);
      `check_eq("bypass", 1'b1, div_bypass)
      // Differential types and polarities; single ended enables must not matter
      reg_write(ocdpc_pkg::ADDR_SINGLE, 8'hfc);
      for (int t = 0; t < 6; t++) begin
         for (int p = 0; p < 4; p++) begin
            reg_write(ocdpc_pkg::ADDR_DRIVER, 8'(p * 16 + t * 2));
            settle(3);
            exp4 = {1'b1, pol_of(2'(p), 1'b1), 1'b1, ~pol_of(2'(p), 1'b1)};
            `check_eq("diff type", 3'(t), driver_type)
            `check_eq("diff pins", exp4, {out_p_oe, out_p, out_n_oe, out_n})
         end
      end
      // Single ended types over every enable and polarity combination
      for (int t = 6; t < 8; t++) begin
         reg_write(ocdpc_pkg::ADDR_DRIVER, 8'(16 + t * 2));
         for (int k = 0; k < 64; k++) begin
            reg_write(ocdpc_pkg::ADDR_SINGLE, 8'(k * 4));
            settle(3);
            exp4 = {k[5], k[5] & pol_of(k[4:3], 1'b1), k[2], k[2] & pol_of(k[1:0], 1'b1)};
            `check_eq("se pins", exp4, {out_p_oe, out_p, out_n_oe, out_n})
         end
      end
      reg_write(ocdpc_pkg::ADDR_SINGLE, 8'h04);
      // Power down holds the pin static, even through a sync
      reg_write(ocdpc_pkg::ADDR_DRIVER, 8'h94);
      settle(3);
      @(posedge clk_sys);
      sync_req <= 1'b1;
      @(posedge clk_sys);
      sync_req <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         @(negedge clk_sys);
         `check_eq("power down", 1'b0, out_p)
      end
      reg_write(ocdpc_pkg::ADDR_DRIVER, 8'ha4);
      settle(3);
      `check_eq("power down inv", 1'b1, out_p)
      reg_write(ocdpc_pkg::ADDR_DRIVER, 8'h14);
      // Phase offset delays the restart in whole input cycles
      for (int i = 0; i < 3; i++) begin
         set_phase(ph_v[i]);
         sync_lat(lat);
         `check_eq("sync delay", 32'(1 + (ph_v[i] >> 1)), lat)
         `check_eq("half step", ph_v[i][0], half_step)
      end
      // Excluded divider keeps running through a sync
      reg_write(ocdpc_pkg::ADDR_DRIVER, 8'h54);
      set_phase(11'h002);
      sync_lat(lat);
      `check_eq("sync excluded", 0, lat)
      reg_write(ocdpc_pkg::ADDR_DRIVER, 8'h14);
      // Divide ratios including the largest
      for (int i = 0; i < 3; i++) begin
         set_div(dv_v[i]);
         sync_lat(lat);
         `check_eq("no bypass", 1'b0, div_bypass)
         settle(2 * dv_v[i] + 12);
         `check_eq("period", 16'(dv_v[i] + 1), period)
         `check_eq("high time", 16'((dv_v[i] + 2) / 2), high_time)
      end
      finish_test();
   end
endmodule
`default_nettype wire
